// ---- rtl/tasl_consts.svh ----
// Register offsets, reset values and timing figures of the thermal alert block
`ifndef TASL_CONSTS_SVH
`define TASL_CONSTS_SVH
`define A_CFG1      8'h01
`define A_CFG2      8'h02
`define A_CFG4      8'h04
`define A_FQ        8'h06
`define A_MASK1     8'h08
`define A_MASK2     8'h09
`define A_MASK3     8'h0a
`define A_PCT_LIM   8'h19
`define A_HYS       8'h1a
`define A_RATE      8'h22
`define A_ONTIME    8'h4e
`define A_STAT1     8'h4f
`define A_STAT2     8'h50
`define A_STAT3     8'h51
`define CFG1_BITS   8'h0c
`define CFG1_COMP   3
`define CFG1_TIN    2
`define CFG2_BITS   8'h02
`define CFG2_NOBST  1
`define CFG4_BITS   8'hf3
`define CFG4_REF    7
`define FQ_BITS     8'h0f
`define M1_BITS     8'hf8
`define M2_BITS     8'h1c
`define M3_BITS     8'hc0
`define M2_COMP     8'h18
`define S3_ALERT    0
`define PCT_LIM_RST 8'hff
`define HYS_RST     8'h04
`define RATE_RST    8'h07
`define RATE_MAX    8'h0a
`define RATE_NOAVG  8'h08
`define FQ_FULL     3'h4
`define WIN_SEL_MAX 3'h5
`define WIN_SLICES  8'hff
`define WIN_BASE_MS 250
`define CLK_MHZ     200
`endif

// ---- rtl/tasl_pkg.sv ----
// Types shared by the thermal alert block and its surroundings
package tasl_pkg;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tasl_req_t;
  typedef struct packed {
    logic       loc_valid;
    logic       rem_valid;
    logic       local_high_exceeded;
    logic       local_low_exceeded;
    logic       remote_high_exceeded;
    logic       remote_low_exceeded;
    logic       remote_diode_fault;
    logic [1:0] overtemp_pin_over;
    logic [1:0] overtemp_pin_below_hys;
  } tasl_meas_t;
  typedef struct packed {
    logic [7:0] code;
    logic       averaging_en;
  } tasl_rate_t;
  typedef enum logic {TW_IDLE, TW_RUN} tasl_win_t;
endpackage

// ---- rtl/tasl_top.sv ----
// Alert, status, fault queue, rate and overtemperature pin logic
`timescale 1ns/1ps
`include "tasl_consts.svh"
module tasl_top #(
  parameter int unsigned SLICE_BASE_CYC = `WIN_BASE_MS * `CLK_MHZ * 1000 / 255
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire tasl_pkg::tasl_req_t req,
  output logic [7:0]               reg_rdata,
  input  wire logic                ara_done,
  input  wire tasl_pkg::tasl_meas_t meas,
  input  wire logic                loop_done,
  input  wire logic                fan_one_stalled,
  input  wire logic                fan_alarm_speed,
  input  wire logic                overtemp_pin_in,
  output logic                     overtemp_pin_out,
  output logic                     overtemp_pin_oe_n,
  output logic                     fan_fault_out,
  output logic                     fan_fault_oe_n,
  output logic                     fan_boost,
  output logic                     alert_n,
  output logic [7:0]               overtemp_hysteresis,
  output tasl_pkg::tasl_rate_t     rate_out
);
  import tasl_pkg::*;

  function automatic logic hit(input tasl_req_t r, input logic [7:0] a);
    hit = r.addr == a;
  endfunction

  function automatic logic [2:0] fq_depth(input logic [3:0] f);
    fq_depth = f[3] ? 3'h4 : f[2] ? 3'h3 : f[1] ? 3'h2 : 3'h1;
  endfunction

  function automatic logic [2:0] fq_step(input logic [2:0] c, input logic o);
    fq_step = !o ? 3'h0 : (c == `FQ_FULL) ? c : c + 3'h1;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] cfg1, cfg2, cfg4, fq, mask1, mask2, mask3, pct_lim, on_time;
  logic [7:0] stat1, stat2, stat3, rate_req;
  logic [4:0] temp_live;
  logic [2:0] loc_cnt, rem_cnt;
  logic       loc_fill, rem_fill;
  logic       over_state, pct_over;
  tasl_win_t  win_state;
  logic [31:0] slice_cnt, acc_cnt;
  logic [7:0] slice_idx, pct_cnt;
  logic [7:0] rd_mux;

  wire wr = req.wr;
  wire rd = req.rd;
  wire comp_mode = cfg1[`CFG1_COMP];
  wire pin_input = cfg1[`CFG1_TIN];
  wire clr1 = ara_done | (rd & hit(req, `A_STAT1));
  wire clr2 = ara_done | (rd & hit(req, `A_STAT2));
  wire clr3 = ara_done | (rd & hit(req, `A_STAT3));

  wire v_l = meas.loc_valid;
  wire v_r = meas.rem_valid;
  wire [4:0] temp_now = {meas.local_high_exceeded, meas.local_low_exceeded,
                         meas.remote_high_exceeded, meas.remote_low_exceeded,
                         meas.remote_diode_fault};
  wire [4:0] temp_upd = {{2{v_l}}, {3{v_r}}};
  wire [4:0] next_live = (temp_live & ~temp_upd) | (temp_now & temp_upd);
  wire loc_out = |temp_now[4:3];
  wire rem_out = |temp_now[2:0];

  // ----------------------------------------
  // Live conditions and sticky status
  // ----------------------------------------
  wire ts_live = pin_input & ~overtemp_pin_in;
  wire ta_live = over_state;
  wire [7:0] live1 = {next_live, 3'h0};
  wire [7:0] ev1 = {temp_now & temp_upd, 3'h0};
  wire [7:0] live2 = {meas.overtemp_pin_over[0], meas.overtemp_pin_over[1], 1'b0, pct_over,
                      ta_live, ts_live, 2'h0};
  wire [7:0] live3 = {fan_one_stalled, fan_alarm_speed, 6'h0};
  // Set wins over the read-clear; a bit clears only if its cause is gone
  wire [7:0] next_stat1 = (stat1 & ~({8{clr1}} & ~live1)) | ev1;
  wire [7:0] next_stat2 = (stat2 & ~({8{clr2}} & ~live2)) | live2;
  wire [7:0] next_stat3 = (stat3 & ~({8{clr3}} & ~live3)) | live3;

  // ----------------------------------------
  // Fault queues
  // ----------------------------------------
  wire [2:0] depth = fq_depth(fq[3:0]);
  wire [2:0] next_loc = v_l ? fq_step(clr1 ? 3'h0 : loc_cnt, loc_out)
                            : (clr1 ? 3'h0 : loc_cnt);
  wire [2:0] next_rem = v_r ? fq_step(clr1 ? 3'h0 : rem_cnt, rem_out)
                            : (clr1 ? 3'h0 : rem_cnt);

  // ----------------------------------------
  // Queue fill flags
  // ----------------------------------------
  // A full queue stays full until cleared; an in-limit reading alone
  // must not release a latched alert
  wire next_loc_fill = (loc_fill & ~clr1) | (v_l & (next_loc >= depth));
  wire next_rem_fill = (rem_fill & ~clr1) | (v_r & (next_rem >= depth));
  wire loc_full = loc_fill;
  wire rem_full = rem_fill;
  wire [7:0] q_gate = {{2{loc_full}}, {3{rem_full}}, 3'h0};

  // ----------------------------------------
  // Alert
  // ----------------------------------------
  // Queue gating holds the latched alert until a clear drops the fill flag
  wire pend_latch = |(stat1 & ~mask1 & q_gate)
                  | |(stat2 & ~mask2 & `M2_BITS)
                  | |(stat3 & ~mask3 & `M3_BITS);
  wire pend_comp = |(live1 & ~mask1)
                 | |(live2 & ~mask2 & `M2_COMP)
                 | |(live3 & ~mask3 & `M3_BITS);
  wire next_alert_n = ~(comp_mode ? pend_comp : pend_latch);

  // ----------------------------------------
  // Overtemperature pin and fan controls
  // ----------------------------------------
  wire [1:0] chan_en = pin_input ? cfg4[1:0] : 2'h3;
  wire next_over = |(meas.overtemp_pin_over & chan_en) |
                   (over_state & ~&(meas.overtemp_pin_below_hys | ~chan_en));

  // ----------------------------------------
  // Conversion rate
  // ----------------------------------------
  wire rate_ok = req.wdata <= `RATE_MAX;

  // ----------------------------------------
  // Percent on-time window
  // ----------------------------------------
  wire [2:0] sel = (cfg4[6:4] > `WIN_SEL_MAX) ? `WIN_SEL_MAX : cfg4[6:4];
  wire [31:0] slice_len = SLICE_BASE_CYC << sel;
  wire slice_end = slice_cnt == slice_len - 32'h1;
  wire win_end = slice_end & (slice_idx == `WIN_SLICES - 8'h1);
  wire acc_wrap = ~overtemp_pin_in & (acc_cnt == slice_len - 32'h1);
  wire [7:0] next_pct = acc_wrap ? pct_cnt + 8'h1 : pct_cnt;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfg1 <= 8'h00;
      cfg2 <= 8'h00;
      cfg4 <= 8'h00;
      fq <= 8'h00;
      mask1 <= 8'h00;
      mask2 <= 8'h00;
      mask3 <= 8'h00;
      pct_lim <= `PCT_LIM_RST;
      overtemp_hysteresis <= `HYS_RST;
      rate_req <= `RATE_RST;
    end else if (wr) begin
      // Only implemented bits store; reserved bits stay zero
      if (hit(req, `A_CFG1)) cfg1 <= req.wdata & `CFG1_BITS;
      if (hit(req, `A_CFG2)) cfg2 <= req.wdata & `CFG2_BITS;
      if (hit(req, `A_CFG4)) cfg4 <= req.wdata & `CFG4_BITS;
      if (hit(req, `A_FQ)) fq <= req.wdata & `FQ_BITS;
      if (hit(req, `A_MASK1)) mask1 <= req.wdata & `M1_BITS;
      if (hit(req, `A_MASK2)) mask2 <= req.wdata & `M2_BITS;
      if (hit(req, `A_MASK3)) mask3 <= req.wdata & `M3_BITS;
      if (hit(req, `A_PCT_LIM)) pct_lim <= req.wdata;
      if (hit(req, `A_HYS)) overtemp_hysteresis <= req.wdata;
      if (hit(req, `A_RATE) && rate_ok) rate_req <= req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stat1 <= 8'h00;
      stat2 <= 8'h00;
      stat3 <= 8'h00;
      temp_live <= 5'h00;
      loc_cnt <= 3'h0;
      rem_cnt <= 3'h0;
      loc_fill <= 1'b0;
      rem_fill <= 1'b0;
      alert_n <= 1'b1;
    end else begin
      stat1 <= next_stat1;
      stat2 <= next_stat2;
      stat3 <= next_stat3;
      temp_live <= next_live;
      loc_cnt <= next_loc;
      rem_cnt <= next_rem;
      loc_fill <= next_loc_fill;
      rem_fill <= next_rem_fill;
      alert_n <= next_alert_n;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      over_state <= 1'b0;
      overtemp_pin_out <= 1'b0;
      overtemp_pin_oe_n <= 1'b1;
      fan_boost <= 1'b0;
      fan_fault_out <= 1'b1;
      fan_fault_oe_n <= 1'b1;
      rate_out <= '{code: `RATE_RST, averaging_en: 1'b1};
    end else begin
      over_state <= next_over;
      overtemp_pin_out <= 1'b0;
      overtemp_pin_oe_n <= ~next_over;
      fan_boost <= next_over & ~cfg2[`CFG2_NOBST];
      fan_fault_out <= 1'b0;
      // In reference mode the pin is an analog input, never driven
      fan_fault_oe_n <= cfg4[`CFG4_REF] | ~fan_one_stalled;
      if (loop_done) begin
        rate_out.code <= rate_req;
        rate_out.averaging_en <= rate_req < `RATE_NOAVG;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      win_state <= TW_IDLE;
      slice_cnt <= 32'h0;
      acc_cnt <= 32'h0;
      slice_idx <= 8'h00;
      pct_cnt <= 8'h00;
      on_time <= 8'h00;
      pct_over <= 1'b0;
    end else begin
      case (win_state)
        TW_IDLE: begin
          slice_cnt <= 32'h0;
          acc_cnt <= 32'h0;
          slice_idx <= 8'h00;
          pct_cnt <= 8'h00;
          if (pin_input) begin
            win_state <= TW_RUN;
          end
        end
        TW_RUN: begin
          slice_cnt <= slice_end ? 32'h0 : slice_cnt + 32'h1;
          if (slice_end) begin
            slice_idx <= slice_idx + 8'h1;
          end
          if (acc_wrap) begin
            acc_cnt <= 32'h0;
          end else if (!overtemp_pin_in) begin
            acc_cnt <= acc_cnt + 32'h1;
          end
          pct_cnt <= next_pct;
          // A zero limit trips on the first assertion
          if (ts_live && pct_lim == 8'h00) begin
            pct_over <= 1'b1;
          end
          if (win_end) begin
            on_time <= next_pct;
            pct_over <= next_pct > pct_lim;
            slice_idx <= 8'h00;
            acc_cnt <= 32'h0;
            pct_cnt <= 8'h00;
          end
          if (!pin_input) begin
            win_state <= TW_IDLE;
          end
        end
        default: win_state <= TW_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    case (req.addr)
      `A_CFG1: rd_mux = cfg1;
      `A_CFG2: rd_mux = cfg2;
      `A_CFG4: rd_mux = cfg4;
      `A_FQ: rd_mux = fq;
      `A_MASK1: rd_mux = mask1;
      `A_MASK2: rd_mux = mask2;
      `A_MASK3: rd_mux = mask3;
      `A_PCT_LIM: rd_mux = pct_lim;
      `A_HYS: rd_mux = overtemp_hysteresis;
      `A_RATE: rd_mux = rate_req;
      `A_ONTIME: rd_mux = on_time;
      `A_STAT1: rd_mux = stat1;
      `A_STAT2: rd_mux = stat2;
      `A_STAT3: rd_mux = stat3 | {7'h00, ~alert_n};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  AST_COMP_FOLLOWS: assert property (comp_mode & pend_comp |=> !alert_n)
    else $error("comparator alert not low");
  AST_LATCH_LOW: assert property (!comp_mode & ~cfg1[`CFG1_COMP] & pend_latch |=> !alert_n)
    else $error("latched alert not low");
  AST_MASK_STATUS: assert property (v_l & meas.local_high_exceeded |=> stat1[7])
    else $error("masked source did not set status");
  AST_STICKY: assert property (stat1[7] & !clr1 |=> stat1[7])
    else $error("status bit dropped without read");
  AST_QUEUE_CLR: assert property (ara_done & !v_l |=> loc_cnt == 3'h0)
    else $error("fault queue not cleared");
  AST_QUEUE_FILL: assert property ($rose(loc_full) |-> $past(v_l) & $past(loc_out))
    else $error("queue filled without reading");
  AST_RATE_HOLD: assert property (!loop_done |=> $stable(rate_out.code))
    else $error("rate changed mid loop");
  AST_BOOST: assert property (next_over & !cfg2[`CFG2_NOBST] |=> fan_boost)
    else $error("fans not boosted");
  AST_REF_NODRIVE: assert property (cfg4[`CFG4_REF] |=> fan_fault_oe_n)
    else $error("fan fault pin driven in ref mode");
  AST_RSVD: assert property (rd & hit(req, `A_MASK1) |=> reg_rdata[2:0] == 3'h0)
    else $error("reserved mask bits nonzero");
  AST_FILL_HOLD: assert property (loc_fill & !clr1 |=> loc_fill)
    else $error("full queue dropped without clear");
  AST_REM_CLR: assert property (ara_done & !v_r |=> !rem_fill)
    else $error("remote queue not cleared");
  AST_RATE_RANGE: assert property (rate_req <= `RATE_MAX)
    else $error("reserved rate code stored");
  AST_AVG_OFF: assert property (rate_out.code >= `RATE_NOAVG |-> !rate_out.averaging_en)
    else $error("averaging on at fast rate");
  AST_PIN_INPUT: assert property (pin_input & (cfg4[1:0] == 2'h0) |=> overtemp_pin_oe_n)
    else $error("overtemperature pin driven in input mode");
  AST_STALL_STATUS: assert property (fan_one_stalled |=> stat3[7])
    else $error("stall status not set");
  AST_COMP_RELEASE: assert property (comp_mode & !pend_comp |=> alert_n)
    else $error("comparator alert not released");

  COV_LATCH: cover property (!comp_mode ##1 $fell(alert_n) ##[1:20] $rose(alert_n));
  COV_COMP: cover property (comp_mode & pend_comp ##1 !alert_n);
  COV_WIN: cover property (win_end);
  COV_RATE: cover property (loop_done & (rate_req != rate_out.code));
  COV_REFILL: cover property ($fell(loc_fill) ##[1:40] $rose(loc_fill));
endmodule

// ---- verification/tasl_host_model.sv ----
// Alert-servicing host model that answers a low alert with one alert response
`timescale 1ns/1ps
module tasl_host_model (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       en,
  input  wire logic [2:0] lat,
  input  wire logic       alert_n,
  output logic            ara_done
);
  logic [2:0] dly;
  logic       served;
  // One response per alert episode; lat sets how slow the host is
  always_ff @(posedge core_clk) begin
    if (!nrst || !en) begin
      dly      <= 3'h0;
      served   <= 1'b0;
      ara_done <= 1'b0;
    end else begin
      ara_done <= 1'b0;
      if (alert_n) begin
        dly    <= 3'h0;
        served <= 1'b0;
      end else if (!served) begin
        dly <= dly + 3'h1;
        if (dly == lat) begin
          ara_done <= 1'b1;
          served   <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the thermal alert block
`timescale 1ns/1ps
`include "tasl_consts.svh"
module testbench;
  import tasl_pkg::*;
  logic       core_clk = 1'b0;
  logic       nrst     = 1'b0;
  tasl_req_t  req      = '0;
  tasl_meas_t meas     = '0;
  logic       loop_done = 1'b0;
  logic       fs       = 1'b0;
  logic       fa       = 1'b0;
  logic       host_en  = 1'b0;
  logic       pin      = 1'b1;
  logic       ara_done;
  logic [7:0] rdata;
  logic [7:0] hys;
  logic       oe_n;
  logic       fo_n;
  logic       po;
  logic       ffo;
  logic       boost;
  logic       alert_n;
  tasl_rate_t rate;
  int         n_fail = 0;
  int         total_checks = 0;
  logic [7:0] fq_code [4] = '{8'h01, 8'h03, 8'h07, 8'h0f};

  always #2.5 core_clk = ~core_clk;

  tasl_top #(.SLICE_BASE_CYC(4)) uut (
    .core_clk(core_clk), .nrst(nrst), .req(req), .reg_rdata(rdata),
    .ara_done(ara_done), .meas(meas), .loop_done(loop_done),
    .fan_one_stalled(fs), .fan_alarm_speed(fa), .overtemp_pin_in(pin),
    .overtemp_pin_out(po), .overtemp_pin_oe_n(oe_n), .fan_fault_out(ffo),
    .fan_fault_oe_n(fo_n), .fan_boost(boost), .alert_n(alert_n),
    .overtemp_hysteresis(hys), .rate_out(rate)
  );

  tasl_host_model u_host (
    .core_clk(core_clk), .nrst(nrst), .en(host_en), .lat(3'h2),
    .alert_n(alert_n), .ara_done(ara_done)
  );

  task results;
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task chk(input string nm, input logic [8:0] g, input logic [8:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task do_rst;
    cyc(1);
    nrst = 1'b0;
    meas = '0;
    fs = 1'b0;
    fa = 1'b0;
    pin = 1'b1;
    cyc(3);
    nrst = 1'b1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    req.rd = 1'b1;
    req.addr = a;
    cyc(1);
    req.rd = 1'b0;
    cyc(1);
    chk(nm, {1'b0, rdata}, {1'b0, e});
  endtask
  task lhi(input logic f);
    meas.loc_valid = 1'b1;
    meas.local_high_exceeded = f;
    cyc(1);
    meas.loc_valid = 1'b0;
    cyc(1);
  endtask
  task rhi(input logic f);
    meas.rem_valid = 1'b1;
    meas.remote_high_exceeded = f;
    cyc(1);
    meas.rem_valid = 1'b0;
    cyc(1);
  endtask
  task ca(input logic e);
    chk("alert_n", {8'h00, alert_n}, {8'h00, e});
  endtask
  // Bounded wait; a wait that runs out ends the run
  task walert(input logic e);
    for (int i = 0; i < 20 && alert_n !== e; i++) cyc(1);
    ca(e);
    if (alert_n !== e) results;
  endtask

  task t_regs;
    do_rst();
    chk("rate", rate, {8'h07, 1'b1});
    chk("hys", {1'b0, hys}, 9'h004);
    ca(1'b1);
    rd(`A_MASK1, 8'h00, "mask1");
    wr(`A_MASK1, 8'hff);
    rd(`A_MASK1, 8'hf8, "mask1");
    wr(`A_MASK2, 8'hff);
    rd(`A_MASK2, 8'h1c, "mask2");
    wr(`A_MASK3, 8'hff);
    rd(`A_MASK3, 8'hc0, "mask3");
  endtask
  task t_latched;
    do_rst();
    lhi(1'b1);
    cyc(2);
    ca(1'b0);
    lhi(1'b0);
    cyc(4);
    ca(1'b0);
    rd(`A_STAT1, 8'h80, "stat1");
    walert(1'b1);
    rd(`A_STAT1, 8'h00, "stat1");
  endtask
  task t_mask;
    do_rst();
    wr(`A_MASK1, 8'h80);
    lhi(1'b1);
    cyc(3);
    ca(1'b1);
    rd(`A_STAT1, 8'h80, "stat1");
  endtask
  task t_depth;
    for (int k = 0; k < 4; k++) begin
      do_rst();
      wr(`A_FQ, fq_code[k]);
      repeat (k) lhi(1'b1);
      cyc(2);
      ca(1'b1);
      lhi(1'b1);
      cyc(2);
      ca(1'b0);
    end
  endtask
  task t_ara;
    do_rst();
    wr(`A_FQ, 8'h07);
    lhi(1'b1);
    lhi(1'b1);
    lhi(1'b0);
    lhi(1'b1);
    lhi(1'b1);
    cyc(2);
    ca(1'b1);
    host_en = 1'b1;
    lhi(1'b1);
    cyc(2);
    ca(1'b0);
    walert(1'b1);
    host_en = 1'b0;
    lhi(1'b1);
    lhi(1'b1);
    cyc(2);
    ca(1'b1);
    lhi(1'b1);
    cyc(2);
    ca(1'b0);
    rd(`A_STAT1, 8'h80, "stat1");
    walert(1'b1);
    lhi(1'b1);
    cyc(2);
    ca(1'b1);
  endtask
  task t_comp;
    do_rst();
    wr(`A_CFG1, 8'h08);
    wr(`A_FQ, 8'h0f);
    lhi(1'b1);
    cyc(2);
    ca(1'b0);
    lhi(1'b0);
    walert(1'b1);
  endtask
  task t_rate;
    do_rst();
    wr(`A_RATE, 8'h08);
    wr(`A_RATE, 8'h0b);
    cyc(2);
    chk("rate", rate, {8'h07, 1'b1});
    rd(`A_RATE, 8'h08, "rate reg");
    loop_done = 1'b1;
    cyc(1);
    loop_done = 1'b0;
    chk("rate", rate, {8'h08, 1'b0});
    wr(`A_RATE, 8'h07);
    loop_done = 1'b1;
    cyc(1);
    loop_done = 1'b0;
    chk("rate", rate, {8'h07, 1'b1});
  endtask
  task t_pin;
    for (int b = 0; b < 2; b++) begin
      do_rst();
      if (b == 1) wr(`A_CFG2, 8'h02);
      meas.overtemp_pin_over = 2'b01;
      cyc(1);
      chk("oe_n", {8'h00, oe_n}, 9'h000);
      chk("boost", {8'h00, boost}, {8'h00, b == 0});
      chk("pin_out", {8'h00, po}, 9'h000);
      meas.overtemp_pin_over = 2'b00;
      meas.overtemp_pin_below_hys = 2'b11;
      cyc(2);
      chk("oe_n", {8'h00, oe_n}, 9'h001);
    end
    do_rst();
    wr(`A_CFG1, 8'h04);
    meas.overtemp_pin_over = 2'b01;
    cyc(2);
    chk("oe_n", {8'h00, oe_n}, 9'h001);
  endtask
  task t_fan;
    do_rst();
    fs = 1'b1;
    fa = 1'b1;
    cyc(1);
    chk("fan_n", {8'h00, fo_n}, 9'h000);
    chk("fan_out", {8'h00, ffo}, 9'h000);
    cyc(2);
    rd(`A_STAT3, 8'hc1, "stat3");
    wr(`A_CFG4, 8'h80);
    cyc(1);
    chk("fan_n", {8'h00, fo_n}, 9'h001);
  endtask
  task t_chan;
    do_rst();
    wr(`A_FQ, 8'h03);
    lhi(1'b1);
    rhi(1'b1);
    cyc(2);
    ca(1'b1);
    rhi(1'b1);
    cyc(2);
    ca(1'b0);
    rd(`A_STAT1, 8'ha0, "stat1");
    walert(1'b1);
  endtask
  task t_overtemp_pin;
    do_rst();
    wr(`A_PCT_LIM, 8'h7f);
    pin = 1'b0;
    wr(`A_CFG1, 8'h04);
    // One full window of 255 slices of 4 cycles, plus margin
    cyc(1030);
    rd(`A_ONTIME, 8'hff, "on_time");
    rd(`A_STAT2, 8'h14, "stat2");
    ca(1'b0);
  endtask

  initial begin
    #400000;
    n_fail++;
    results;
  end
  initial begin
    t_regs();
    t_latched();
    t_mask();
    t_depth();
    t_ara();
    t_comp();
    t_rate();
    t_pin();
    t_fan();
    t_chan();
    t_overtemp_pin();
    results;
  end
endmodule
